// ===== core/byte_stream_buffer.sv
// Small valid/ready FIFO that stages bytes ahead of the shared RAM.
// Assumes both sides run on clk_sys; source sees back-pressure through in_ready.
`timescale 1ns/1ps
module byte_stream_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

	// Whole state of the buffer
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
		logic [PW-1:0]               wr;  // Write index
		logic [PW-1:0]               rd;  // Read index
		logic [CW-1:0]               cnt; // Occupancy
	} buf_s;

	buf_s s_r;    // Registered state
	buf_s s_nxt;  // Next state

	// Honest full and empty
	assign in_ready  = (s_r.cnt != DEPTH_C);
	assign out_valid = (s_r.cnt != '0);
	assign out_data  = s_r.mem[s_r.rd];

	// Push and pop, both allowed in one cycle
	always_comb begin
		s_nxt = s_r;
		if (in_valid && in_ready) begin
			s_nxt.mem[s_r.wr] = in_data;
			s_nxt.wr          = PW'((s_r.wr == PW'(DEPTH - 1)) ? 0 : s_r.wr + 1'b1);
		end
		if (out_valid && out_ready) begin
			s_nxt.rd = PW'((s_r.rd == PW'(DEPTH - 1)) ? 0 : s_r.rd + 1'b1);
		end
		s_nxt.cnt = CW'(s_r.cnt + CW'(in_valid && in_ready) - CW'(out_valid && out_ready));
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// ===== core/fifo_mgr_pkg.sv
// Constants shared by the byte FIFO manager and its receive staging buffer.
// Assumes an 8-bit special function register bus on the CPU clock.
package fifo_mgr_pkg;
	// Register addresses on the special function register bus
	localparam logic [7:0] ADDR_FIFO_STATUS     = 8'h9F;
	localparam logic [7:0] ADDR_FIFO_IRQ_EN_FL  = 8'hA1;
	localparam logic [7:0] ADDR_FIFO_DATA_PORT  = 8'hA2;
	localparam logic [7:0] ADDR_RX_FIFO_LENGTH  = 8'hA3;
	// Field positions in the enable-and-clear register, and BIT_STATUS_CLEAR in the status register
	localparam int         BIT_TX_POINTER_CLEAR = 7;
	localparam int         BIT_RX_POINTER_CLEAR = 6;
	localparam int         BIT_STATUS_CLEAR     = 7;
	// Flag and enable order, bit 5 down to 0
	localparam int         FLG_WCOL             = 5;
	localparam int         FLG_TX_LOW           = 4;
	localparam int         FLG_TX_FULL          = 3;
	localparam int         FLG_RX_HIGH          = 2;
	localparam int         FLG_RX_OVR           = 1;
	localparam int         FLG_RX_FULL          = 0;
	localparam int         NUM_FLAGS            = 6;
	// Reset values
	localparam logic [7:0] RST_BYTE             = 8'h00;
	localparam logic [5:0] RST_ENABLE           = 6'h00;
	// Shared RAM geometry and watermark thresholds
	localparam int         RAM_BYTES            = 256;
	localparam logic [8:0] RAM_BYTES_W          = 9'h100;
	localparam logic [8:0] RX_LENGTH_MAX        = 9'h0B6;
	localparam logic [8:0] TX_LOW_MARK          = 9'h010;
	localparam logic [8:0] RX_HIGH_MARK         = 9'h010;
	// Receive staging buffer shape
	localparam int         RX_BUF_DEPTH         = 4;
	localparam int         BYTE_W               = 8;
endpackage

// ===== core/shared_ram_byte_fifo_manager.sv
// Byte FIFO manager: one shared RAM split into a receive and a transmit queue.
// Assumes a one-cycle SFR strobe bus and a serial port with valid/ready byte streams.
//
// How it works
// - Transmit clear bit empties transmit queue
// - Receive clear bit empties receive queue
// - Enable bits 5..0 gate matching flags
// - Data port write appends to transmit tail
// - Data port read pops oldest received byte
// - Length register sets receive capacity, any value 0 to 255, unclamped
// - Transmit capacity is RAM minus receive length
// - Full receive queue drops new bytes
// - Receive byte buffered while earlier ones stored
// - Gated flags OR into one interrupt
// - Data write while transmit full flags collision
// - Byte arriving while receive full flags overrun
`timescale 1ns/1ps
module shared_ram_byte_fifo_manager
	import fifo_mgr_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       fifo_enable,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       rx_byte_valid,
	output logic            rx_byte_ready,
	input  wire logic [7:0] rx_byte_data,
	output logic            tx_byte_valid,
	input  wire logic       tx_byte_ready,
	output logic      [7:0] tx_byte_data,
	output logic            fifo_irq
);
	// Whole state of the manager
	typedef struct packed {
		logic [RAM_BYTES-1:0][7:0] ram;     // Shared RAM
		logic [5:0]                enable;  // Per-flag enables
		logic [7:0]                rx_len;  // Receive region length
		logic                      wcol;    // Sticky write collision
		logic                      rovr;    // Sticky read overrun
		logic [7:0]                rx_wr;   // Receive tail index
		logic [7:0]                rx_rd;   // Receive head index
		logic [8:0]                rx_cnt;  // Receive occupancy
		logic [7:0]                tx_wr;   // Transmit tail index
		logic [7:0]                tx_rd;   // Transmit head index
		logic [8:0]                tx_cnt;  // Transmit occupancy
		logic [7:0]                rdata;   // Read data register
		logic                      txo_vld; // Output stage holds a byte
		logic [7:0]                txo_dat; // Output stage byte
	} mgr_s;

	mgr_s s_r;    // Registered state
	mgr_s s_nxt;  // Next state

	logic       buf_valid;  // Staged receive byte present
	logic       buf_ready;  // Manager takes staged byte
	logic [7:0] buf_data;   // Staged receive byte
	logic [8:0] tx_cap;     // Transmit capacity
	logic       rx_full;    // Receive queue full
	logic       tx_full;    // Transmit queue full
	logic [5:0] flags;      // Current event flags
	logic       wr_fl;      // Write to enable-and-clear register
	logic       wr_data;    // Write to data port
	logic       rd_data;    // Read of data port
	logic       tx_take;    // Output stage reloads
	logic       fl_tx;      // Transmit clear this cycle
	logic       fl_rx;      // Receive clear this cycle

	// Advance an index inside a region of the given capacity
	function automatic logic [7:0] next_idx(input logic [7:0] idx, input logic [8:0] cap);
		next_idx = (({1'b0, idx} + 9'h001) >= cap) ? 8'h00 : 8'(idx + 8'h01);
	endfunction

	// Staging buffer keeps serial reception going while the receive queue clears, and takes up to four bytes while the manager is off
	byte_stream_buffer #(
		.WIDTH (BYTE_W),
		.DEPTH (RX_BUF_DEPTH)
	) u_rx_stage (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (rx_byte_valid),
		.in_ready  (rx_byte_ready),
		.in_data   (rx_byte_data),
		.out_valid (buf_valid),
		.out_ready (buf_ready),
		.out_data  (buf_data)
	);

	// Status derived from occupancy and the sticky bits, so a clear shows one cycle later
	always_comb begin
		tx_cap                = 9'(RAM_BYTES_W - {1'b0, s_r.rx_len});
		rx_full               = (s_r.rx_cnt >= {1'b0, s_r.rx_len});
		tx_full               = (s_r.tx_cnt >= tx_cap);
		flags[FLG_WCOL]       = s_r.wcol;
		flags[FLG_TX_LOW]     = (s_r.tx_cnt <= TX_LOW_MARK);
		flags[FLG_TX_FULL]    = tx_full;
		flags[FLG_RX_HIGH]    = (s_r.rx_cnt >= RX_HIGH_MARK);
		flags[FLG_RX_OVR]     = s_r.rovr;
		flags[FLG_RX_FULL]    = rx_full;
	end

	// Bus decode and handshakes
	assign wr_fl     = fifo_enable && sfr_wr && (sfr_addr == ADDR_FIFO_IRQ_EN_FL);
	assign wr_data   = fifo_enable && sfr_wr && (sfr_addr == ADDR_FIFO_DATA_PORT);
	assign rd_data   = fifo_enable && sfr_rd && (sfr_addr == ADDR_FIFO_DATA_PORT);
	assign fl_tx     = wr_fl && sfr_wdata[BIT_TX_POINTER_CLEAR];
	assign fl_rx     = wr_fl && sfr_wdata[BIT_RX_POINTER_CLEAR];
	assign buf_ready = fifo_enable && !fl_rx; // Stall staging during clear
	assign tx_take   = fifo_enable && (!s_r.txo_vld || tx_byte_ready) && (s_r.tx_cnt != 9'h000);

	// Gated flags ORed onto the single request line
	assign fifo_irq      = |(flags & s_r.enable);
	assign sfr_rdata     = s_r.rdata;
	assign tx_byte_valid = s_r.txo_vld;
	assign tx_byte_data  = s_r.txo_dat;

	// Next-state logic
	always_comb begin
		s_nxt = s_r;
		// Output stage handed over
		if (tx_byte_ready) begin
			s_nxt.txo_vld = 1'b0;
		end
		if (fifo_enable) begin
			// Register writes
			if (wr_fl) begin
				s_nxt.enable = sfr_wdata[5:0];
			end
			if (sfr_wr && (sfr_addr == ADDR_RX_FIFO_LENGTH)) begin
				s_nxt.rx_len = sfr_wdata;
			end
			// Sticky flag clear: bit 7 set clears the bits set in the write
			if (sfr_wr && (sfr_addr == ADDR_FIFO_STATUS) && sfr_wdata[BIT_STATUS_CLEAR]) begin
				if (sfr_wdata[FLG_WCOL]) begin
					s_nxt.wcol = 1'b0;
				end
				if (sfr_wdata[FLG_RX_OVR]) begin
					s_nxt.rovr = 1'b0;
				end
			end
			// Transmit push, or collision when full
			if (wr_data) begin
				if (tx_full) begin
					s_nxt.wcol = 1'b1;
				end else begin
					s_nxt.ram[8'(s_r.rx_len + s_r.tx_wr)] = sfr_wdata;
					s_nxt.tx_wr = next_idx(s_r.tx_wr, tx_cap);
				end
			end
			// Transmit drain into the output stage
			if (tx_take) begin
				s_nxt.txo_vld = 1'b1;
				s_nxt.txo_dat = s_r.ram[8'(s_r.rx_len + s_r.tx_rd)];
				s_nxt.tx_rd   = next_idx(s_r.tx_rd, tx_cap);
			end
			s_nxt.tx_cnt = 9'(s_r.tx_cnt + 9'(wr_data && !tx_full) - 9'(tx_take));
			// Receive store, or drop when full
			if (buf_valid && buf_ready) begin
				if (rx_full) begin
					s_nxt.rovr = 1'b1;
				end else begin
					s_nxt.ram[s_r.rx_wr] = buf_data;
					s_nxt.rx_wr = next_idx(s_r.rx_wr, {1'b0, s_r.rx_len});
				end
			end
			// Register reads
			if (sfr_rd) begin
				unique case (sfr_addr)
					ADDR_FIFO_IRQ_EN_FL: s_nxt.rdata = {2'b00, s_r.enable};
					ADDR_RX_FIFO_LENGTH: s_nxt.rdata = s_r.rx_len;
					ADDR_FIFO_STATUS:    s_nxt.rdata = {2'b00, flags};
					ADDR_FIFO_DATA_PORT: s_nxt.rdata = s_r.ram[s_r.rx_rd];
					default:             s_nxt.rdata = RST_BYTE;
				endcase
			end
			if (rd_data && (s_r.rx_cnt != 9'h000)) begin
				s_nxt.rx_rd = next_idx(s_r.rx_rd, {1'b0, s_r.rx_len});
			end
			s_nxt.rx_cnt = 9'(s_r.rx_cnt + 9'(buf_valid && buf_ready && !rx_full)
				- 9'(rd_data && (s_r.rx_cnt != 9'h000)));
			// Clears win over same-cycle queue traffic
			if (fl_tx) begin
				s_nxt.tx_wr  = RST_BYTE;
				s_nxt.tx_rd  = RST_BYTE;
				s_nxt.tx_cnt = 9'h000;
			end
			if (fl_rx) begin
				s_nxt.rx_wr  = RST_BYTE;
				s_nxt.rx_rd  = RST_BYTE;
				s_nxt.rx_cnt = 9'h000;
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Named steps of the bus traffic
	sequence seq_tx_clear;
		fl_tx;
	endsequence
	sequence seq_rx_clear;
		fl_rx && !fl_tx;
	endsequence
	sequence seq_push_ok;
		wr_data && !tx_full && !fl_tx;
	endsequence
	sequence seq_pop_ok;
		rd_data && (s_r.rx_cnt != 9'h000);
	endsequence

	AST_TX_CLEAR: assert property (seq_tx_clear |=> (s_r.tx_cnt == 9'h000) && (s_r.tx_wr == 8'h00))
		else $error("transmit queue not emptied by clear");
	AST_RX_CLEAR: assert property (seq_rx_clear |=> (s_r.rx_cnt == 9'h000) && !flags[FLG_RX_HIGH])
		else $error("receive queue not emptied by clear");
	AST_IRQ_GATE: assert property ($rose(s_r.wcol) && s_r.enable[FLG_WCOL] |-> fifo_irq)
		else $error("enabled collision flag missing on interrupt");
	AST_IRQ_QUIET: assert property ((s_r.enable == RST_ENABLE) |-> !fifo_irq)
		else $error("interrupt raised with all enables off");
	AST_TX_PUSH: assert property (seq_push_ok ##1 1'b1 |->
		s_r.ram[8'($past(s_r.rx_len) + $past(s_r.tx_wr))] == $past(sfr_wdata))
		else $error("pushed byte not stored at transmit tail");
	AST_RX_POP: assert property (seq_pop_ok |=> sfr_rdata == $past(s_r.ram[s_r.rx_rd]))
		else $error("data port read did not return oldest byte");
	AST_RX_CAP: assert property ($stable(s_r.rx_len) |-> s_r.rx_cnt <= {1'b0, s_r.rx_len})
		else $error("receive occupancy above programmed length");
	AST_RX_DROP: assert property (buf_valid && buf_ready && rx_full && !rd_data && !fl_rx
		|=> s_r.rovr && $stable(s_r.rx_cnt))
		else $error("byte into full receive queue not dropped");
	AST_WCOL: assert property (wr_data && tx_full |=> s_r.wcol)
		else $error("write into full transmit queue not flagged");
	AST_TX_CAP: assert property ($stable(s_r.rx_len) |-> s_r.tx_cnt <= tx_cap)
		else $error("transmit occupancy above remaining RAM");
endmodule

// ===== dv/serial_port_model.sv
// Serial port stand-in: feeds received bytes, collects transmitted ones.
// Assumes clk_sys from the bench; stall holds the transmit side off.
`timescale 1ns/1ps
module serial_port_model (
	input  wire logic       clk_sys,
	input  wire logic       stall,
	output logic            rx_byte_valid,
	input  wire logic       rx_byte_ready,
	output logic      [7:0] rx_byte_data,
	input  wire logic       tx_byte_valid,
	output logic            tx_byte_ready,
	input  wire logic [7:0] tx_byte_data
);
	logic [7:0] send_q[$]; // Bytes still to offer
	logic [7:0] got_q[$];  // Bytes taken from the block

	// Sink refuses every byte while stalled
	assign tx_byte_ready = ~stall;

	// Offer bytes in order; idle data toggles so stale values never match
	initial begin
		rx_byte_valid = 1'b0;
		rx_byte_data  = 8'h00;
		forever begin
			@(posedge clk_sys);
			if (rx_byte_valid && rx_byte_ready) begin
				void'(send_q.pop_front());
			end
			if (tx_byte_valid && tx_byte_ready) begin
				got_q.push_back(tx_byte_data);
			end
			#1;
			rx_byte_valid = (send_q.size() != 0);
			rx_byte_data  = rx_byte_valid ? send_q[0] : ~rx_byte_data;
		end
	end
endmodule

// ===== dv/test_shared_ram_byte_fifo_manager.sv
// Self-checking bench for the byte FIFO manager.
// Assumes the serial port model on the byte streams and a 250 MHz clock.
`timescale 1ns/1ps
module test_shared_ram_byte_fifo_manager;
	import fifo_mgr_pkg::*;
	typedef struct {logic wr; logic [7:0] a; logic [7:0] d;} row_s;
	logic       clk_sys, rst_n, stall, sfr_wr, sfr_rd, fifo_irq, fifo_en;
	logic       rx_byte_valid, rx_byte_ready, tx_byte_valid, tx_byte_ready;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rx_byte_data, tx_byte_data, s;
	int         n_errors, total_checks;
	// Register rows: write, or read with expected value
	row_s rows [9] = '{'{0, 8'hA1, 8'h00}, '{0, 8'hA3, 8'h00}, '{0, 8'h9F, 8'h11},
		'{1, 8'hA3, 8'h08}, '{0, 8'hA3, 8'h08}, '{1, 8'hA1, 8'h3F}, '{0, 8'hA1, 8'h3F},
		'{1, 8'hA1, 8'h00}, '{0, 8'h50, 8'h00}};

	shared_ram_byte_fifo_manager i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .fifo_enable(fifo_en),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
		.rx_byte_data(rx_byte_data), .tx_byte_valid(tx_byte_valid),
		.tx_byte_ready(tx_byte_ready), .tx_byte_data(tx_byte_data), .fifo_irq(fifo_irq));
	serial_port_model i_port (.clk_sys(clk_sys), .stall(stall), .rx_byte_valid(rx_byte_valid),
		.rx_byte_ready(rx_byte_ready), .rx_byte_data(rx_byte_data),
		.tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready), .tx_byte_data(tx_byte_data));

	// Clock, 4 ns period
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask

	// Closing report
	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One write strobe, then an idle edge
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr  = a;
		sfr_wdata = d;
		sfr_wr    = 1'b1;
		@(posedge clk_sys); #1;
		sfr_wr = 1'b0;
		@(posedge clk_sys); #1;
	endtask

	// One read strobe; data sampled once it has landed
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		sfr_addr = a;
		sfr_rd   = 1'b1;
		@(posedge clk_sys); #1;
		sfr_rd = 1'b0;
		@(posedge clk_sys); #1;
		d = sfr_rdata;
	endtask

	// Poll status under a bound; a miss ends the run
	task automatic wait_status(input logic [7:0] want);
		logic [7:0] v;
		for (int k = 0; k < 60; k++) begin
			reg_rd(ADDR_FIFO_STATUS, v);
			if (v === want) break;
		end
		check(v, want);
		if (v !== want) give_verdict();
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0; stall = 1'b1; sfr_wr = 1'b0; sfr_rd = 1'b0;
		sfr_addr = 8'h00; sfr_wdata = 8'h00; n_errors = 0; total_checks = 0;
		fifo_en = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		// Table rows: reset values, readback, unmapped place
		foreach (rows[i]) begin
			if (rows[i].wr) reg_wr(rows[i].a, rows[i].d);
			else begin
				reg_rd(rows[i].a, s);
				check(s, rows[i].d);
			end
		end
		// Ten bytes into an 8-byte queue: two dropped, overrun set
		for (int i = 0; i < 10; i++) i_port.send_q.push_back(8'h20 + 8'(i));
		wait_status(8'h13);
		// Each enable alone gates its own flag
		for (int i = 0; i < 6; i++) begin
			reg_wr(ADDR_FIFO_IRQ_EN_FL, 8'(1 << i));
			check({7'h00, fifo_irq}, 8'((8'h13 >> i) & 8'h01));
		end
		reg_wr(ADDR_FIFO_IRQ_EN_FL, 8'h00);
		// Oldest first, stored bytes kept
		for (int i = 0; i < 8; i++) begin
			reg_rd(ADDR_FIFO_DATA_PORT, s);
			check(s, 8'h20 + 8'(i));
		end
		reg_wr(ADDR_FIFO_STATUS, 8'h82);
		wait_status(8'h10);
		// Three bytes into the receive queue, ahead of the receive clear
		for (int i = 0; i < 3; i++) i_port.send_q.push_back(8'h60 + 8'(i));
		for (int k = 0; k < 50 && i_port.send_q.size() != 0; k++) @(posedge clk_sys);
		check(8'(i_port.send_q.size()), 8'h00);
		if (i_port.send_q.size() != 0) give_verdict();
		repeat (8) @(posedge clk_sys);
		// Receive clear alone, collision enable switched on with it
		#1 reg_wr(ADDR_FIFO_IRQ_EN_FL, 8'h60);
		i_port.send_q.push_back(8'h77);
		repeat (10) @(posedge clk_sys);
		#1 reg_rd(ADDR_FIFO_DATA_PORT, s);
		check(s, 8'h77);
		// Fill the stalled transmit side: 248 bytes of room plus the output stage
		for (int i = 0; i < 249; i++) reg_wr(ADDR_FIFO_DATA_PORT, 8'(i));
		wait_status(8'h08);
		check({7'h00, fifo_irq}, 8'h00);
		// Three more writes collide
		for (int i = 249; i < 252; i++) reg_wr(ADDR_FIFO_DATA_PORT, 8'(i));
		wait_status(8'h28);
		check({7'h00, fifo_irq}, 8'h01);
		reg_wr(ADDR_FIFO_IRQ_EN_FL, 8'h80);
		wait_status(8'h30);
		check({7'h00, fifo_irq}, 8'h00);
		// Only the byte already staged survives, then new bytes in order
		stall = 1'b0;
		reg_wr(ADDR_FIFO_DATA_PORT, 8'hA5);
		reg_wr(ADDR_FIFO_DATA_PORT, 8'h5A);
		for (int k = 0; k < 50 && i_port.got_q.size() < 3; k++) @(posedge clk_sys);
		repeat (4) @(posedge clk_sys);
		check(8'(i_port.got_q.size()), 8'h03);
		check(i_port.got_q[0], 8'h00);
		check(i_port.got_q[1], 8'hA5);
		check(i_port.got_q[2], 8'h5A);
		// Sticky collision cleared through the status register
		#1 reg_wr(ADDR_FIFO_STATUS, 8'hA0);
		wait_status(8'h10);
		// Length write ignored while the manager is switched off
		fifo_en = 1'b0;
		reg_wr(ADDR_RX_FIFO_LENGTH, 8'h20);
		fifo_en = 1'b1;
		reg_rd(ADDR_RX_FIFO_LENGTH, s);
		check(s, 8'h08);
		// Mid-run reset drives every output to its reset level
		reg_wr(ADDR_FIFO_IRQ_EN_FL, 8'h3F);
		check({7'h00, fifo_irq}, 8'h01);
		rst_n = 1'b0;
		#1;
		check({5'h00, rx_byte_ready, tx_byte_valid, fifo_irq}, 8'h04);
		check(sfr_rdata, 8'h00);
		check(tx_byte_data, 8'h00);
		repeat (2) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		reg_rd(ADDR_RX_FIFO_LENGTH, s);
		check(s, 8'h00);
		reg_rd(ADDR_FIFO_STATUS, s);
		check(s, 8'h11);
		give_verdict();
	end
endmodule
